/* rtl/watchdog_pkg.sv */
// constants for the watchdog control block
package watchdog_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_CONTROL = 32'hBF800000;
  localparam logic [31:0] ADDR_CONTROL_CLR = 32'hBF800004;
  localparam logic [31:0] ADDR_CONTROL_SET = 32'hBF800008;
  localparam logic [31:0] ADDR_CONTROL_INV = 32'hBF80000C;
  localparam logic [31:0] ADDR_CAUSE = 32'hBF80F600;
  localparam logic [31:0] ADDR_CAUSE_CLR = 32'hBF80F604;
  localparam logic [31:0] ADDR_CAUSE_SET = 32'hBF80F608;
  localparam logic [31:0] ADDR_CAUSE_INV = 32'hBF80F60C;
  localparam logic [31:0] ADDR_CONFIG = 32'hBFC02FF8;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hBF800010;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'hBF800014;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ENABLE_BIT = 15;
  localparam int SHADOW_LSB = 2;
  localparam int KICK_BIT = 0;
  localparam int TIMEOUT_BIT = 4;
  localparam int SLEEP_BIT = 3;
  localparam int IDLE_BIT = 2;
  localparam int FORCE_BIT = 23;
  localparam int SELECT_LSB = 16;
  // ---------------------------------------------------------------
  // values and counts
  // ---------------------------------------------------------------
  localparam logic [4:0] SELECT_MAX = 5'h14;
  localparam logic [31:0] CONFIG_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] CAUSE_MASK = 32'h0000001C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] UNDEF_READ = 32'h00000000;
  localparam int COUNT_W = 21;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {PM_AWAKE = 2'h0, PM_SLEEP = 2'h1, PM_IDLE = 2'h2} power_mode_t;
endpackage : watchdog_pkg

/* rtl/pulse_sync.sv */
// two-stage synchroniser with rising-edge pulse for the oscillator tick
`timescale 1ns/10ps
`default_nettype none
module pulse_sync
  import watchdog_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic async,
  output logic rise
);
  logic [SYNC_STAGES:0] stage;
  logic [SYNC_STAGES:0] next_stage;

  // shift the raw level in; only the last two stages feed the edge detector
  always_comb
  begin
    next_stage = {stage[SYNC_STAGES-1:0], async};
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      stage <= '0;
    else
      stage <= next_stage;
  end

  assign rise = stage[SYNC_STAGES-1] & ~stage[SYNC_STAGES];
endmodule : pulse_sync
`default_nettype wire

/* rtl/watchdog_counter.sv */
// watchdog count and timeout detection
`timescale 1ns/10ps
`default_nettype none
module watchdog_counter
  import watchdog_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic running,
  input wire logic tick,
  input wire logic kick,
  input wire logic [4:0] select,
  output logic timeout
);
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [COUNT_W-1:0] limit;
  logic next_timeout;
  logic [4:0] code;

  // count ticks while running, clear on kick or stop, wrap at the ratio
  always_comb
  begin
    code = (select > SELECT_MAX) ? SELECT_MAX : select;
    limit = COUNT_W'((22'h000001 << code) - 22'h000001);
    next_count = count;
    next_timeout = 1'b0;
    if (!running || kick)
      next_count = '0;
    else if (tick)
    begin
      if (count == limit)
      begin
        next_count = '0;
        next_timeout = 1'b1;
      end
      else
        next_count = count + COUNT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      count <= '0;
      timeout <= 1'b0;
    end
    else
    begin
      count <= next_count;
      timeout <= next_timeout;
    end
  end
endmodule : watchdog_counter
`default_nettype wire

/* rtl/watchdog_control_regs.sv */
// watchdog control registers with an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
module watchdog_control_regs
  import watchdog_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] config_word_one,
  input wire logic low_power_rc_osc,
  input wire logic [1:0] power_mode,
  output logic system_reset,
  output logic wake_nmi,
  output logic irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic softEnable, next_softEnable;
  logic [31:0] cause, next_cause;
  logic [31:0] irqStatus, next_irqStatus;
  logic [31:0] irqMask, next_irqMask;
  logic [31:0] configLatch, next_configLatch;
  logic configLoaded, next_configLoaded;
  logic [31:0] awAddrHold, next_awAddrHold;
  logic awHeld, next_awHeld;
  logic [31:0] wDataHold, next_wDataHold;
  logic [3:0] wStrbHold, next_wStrbHold;
  logic wHeld, next_wHeld;
  logic bValidReg, next_bValidReg;
  logic [1:0] bRespReg, next_bRespReg;
  logic rValidReg, next_rValidReg;
  logic [31:0] rDataReg, next_rDataReg;
  logic [1:0] rRespReg, next_rRespReg;
  logic sysResetReg, next_sysResetReg;
  logic wakeReg, next_wakeReg;
  logic running, forceOn, tick, timeout, kick, doWrite;
  logic [4:0] select;
  logic [31:0] wrMask, wrVal, ctrlView;
  power_mode_t mode;

  // ---------------------------------------------------------------
  // watchdog core
  // ---------------------------------------------------------------
  // fuse fields come from the word captured after reset release
  assign forceOn = configLatch[FORCE_BIT];
  assign select = configLatch[SELECT_LSB +: 5];
  assign running = forceOn | softEnable;
  assign mode = power_mode_t'(power_mode);

  pulse_sync pulse_sync_i (
    .clk(clk),
    .resetn(resetn),
    .async(low_power_rc_osc),
    .rise(tick)
  );

  watchdog_counter watchdog_counter_i (
    .clk(clk),
    .resetn(resetn),
    .running(running),
    .tick(tick),
    .kick(kick),
    .select(select),
    .timeout(timeout)
  );

  // control word as read back
  always_comb
  begin
    ctrlView = '0;
    ctrlView[ENABLE_BIT] = running;
    ctrlView[SHADOW_LSB +: 5] = select;
  end

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  // byte strobes expand to a bit mask
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wrMask[i*8 +: 8] = {8{wStrbHold[i]}};
    wrVal = wDataHold & wrMask;
  end

  assign awready = !awHeld;
  assign wready = !wHeld;
  assign doWrite = awHeld && wHeld && !bValidReg;
  // kick is a write of one to bit 0 through the plain, set or invert address
  assign kick = doWrite && wrVal[KICK_BIT] &&
    (awAddrHold == ADDR_CONTROL || awAddrHold == ADDR_CONTROL_SET ||
     awAddrHold == ADDR_CONTROL_INV);

  always_comb
  begin
    next_awAddrHold = awAddrHold;
    next_awHeld = awHeld;
    next_wDataHold = wDataHold;
    next_wStrbHold = wStrbHold;
    next_wHeld = wHeld;
    next_bValidReg = bValidReg;
    next_bRespReg = bRespReg;
    next_softEnable = softEnable;
    next_cause = cause;
    next_irqStatus = irqStatus;
    next_irqMask = irqMask;
    if (awvalid && awready)
    begin
      next_awAddrHold = awaddr;
      next_awHeld = 1'b1;
    end
    if (wvalid && wready)
    begin
      next_wDataHold = wdata;
      next_wStrbHold = wstrb;
      next_wHeld = 1'b1;
    end
    if (bValidReg && bready)
      next_bValidReg = 1'b0;
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValidReg = 1'b1;
      next_bRespReg = RESP_OKAY;
      // reserved control and cause bits are dropped whatever software writes; the irq mask keeps every bit written
      case (awAddrHold)
        ADDR_CONTROL: next_softEnable = wrMask[ENABLE_BIT] ? wrVal[ENABLE_BIT] : softEnable;
        ADDR_CONTROL_CLR: next_softEnable = softEnable & ~wrVal[ENABLE_BIT];
        ADDR_CONTROL_SET: next_softEnable = softEnable | wrVal[ENABLE_BIT];
        ADDR_CONTROL_INV: next_softEnable = softEnable ^ wrVal[ENABLE_BIT];
        ADDR_CAUSE: next_cause = (cause & ~(wrMask & CAUSE_MASK)) | (wrVal & CAUSE_MASK);
        ADDR_CAUSE_CLR: next_cause = cause & ~(wrVal & CAUSE_MASK);
        ADDR_CAUSE_SET: next_cause = cause | (wrVal & CAUSE_MASK);
        ADDR_CAUSE_INV: next_cause = cause ^ (wrVal & CAUSE_MASK);
        ADDR_IRQ_STATUS: next_irqStatus = irqStatus & ~wrVal;
        ADDR_IRQ_MASK: next_irqMask = (irqMask & ~wrMask) | wrVal;
        ADDR_CONFIG: next_bRespReg = RESP_OKAY;
        default: next_bRespReg = RESP_SLVERR;
      endcase
    end
    // hardware events win over a same-cycle software clear
    if (timeout)
    begin
      next_cause[TIMEOUT_BIT] = 1'b1;
      next_irqStatus[TIMEOUT_BIT] = 1'b1;
      if (mode == PM_SLEEP)
        next_cause[SLEEP_BIT] = 1'b1;
      if (mode == PM_IDLE)
        next_cause[IDLE_BIT] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign arready = !rValidReg;

  always_comb
  begin
    next_rValidReg = rValidReg;
    next_rDataReg = rDataReg;
    next_rRespReg = rRespReg;
    if (rValidReg && rready)
      next_rValidReg = 1'b0;
    if (arvalid && arready)
    begin
      next_rValidReg = 1'b1;
      next_rRespReg = RESP_OKAY;
      case (araddr)
        ADDR_CONTROL: next_rDataReg = ctrlView;
        ADDR_CAUSE: next_rDataReg = cause;
        ADDR_CONFIG: next_rDataReg = configLatch;
        ADDR_IRQ_STATUS: next_rDataReg = irqStatus;
        ADDR_IRQ_MASK: next_rDataReg = irqMask;
        ADDR_CONTROL_CLR, ADDR_CONTROL_SET, ADDR_CONTROL_INV,
        ADDR_CAUSE_CLR, ADDR_CAUSE_SET, ADDR_CAUSE_INV: next_rDataReg = UNDEF_READ;
        default:
        begin
          next_rDataReg = '0;
          next_rRespReg = RESP_SLVERR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // timeout outcome and fuse capture
  // ---------------------------------------------------------------
  always_comb
  begin
    next_sysResetReg = timeout && (mode == PM_AWAKE);
    next_wakeReg = timeout && (mode != PM_AWAKE);
    next_configLatch = configLoaded ? configLatch : config_word_one;
    next_configLoaded = 1'b1;
  end

  // register the write channel and the control state
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      softEnable <= 1'b0;
      cause <= '0;
      irqStatus <= '0;
      irqMask <= '0;
      awAddrHold <= '0;
      awHeld <= 1'b0;
      wDataHold <= '0;
      wStrbHold <= '0;
      wHeld <= 1'b0;
      bValidReg <= 1'b0;
      bRespReg <= RESP_OKAY;
    end
    else
    begin
      softEnable <= next_softEnable;
      cause <= next_cause;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      awAddrHold <= next_awAddrHold;
      awHeld <= next_awHeld;
      wDataHold <= next_wDataHold;
      wStrbHold <= next_wStrbHold;
      wHeld <= next_wHeld;
      bValidReg <= next_bValidReg;
      bRespReg <= next_bRespReg;
    end
  end

  // register the read channel
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rValidReg <= 1'b0;
      rDataReg <= '0;
      rRespReg <= RESP_OKAY;
    end
    else
    begin
      rValidReg <= next_rValidReg;
      rDataReg <= next_rDataReg;
      rRespReg <= next_rRespReg;
    end
  end

  // register the timeout outcome and the captured fuse word
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      configLatch <= CONFIG_RESET;
      configLoaded <= 1'b0;
      sysResetReg <= 1'b0;
      wakeReg <= 1'b0;
    end
    else
    begin
      configLatch <= next_configLatch;
      configLoaded <= next_configLoaded;
      sysResetReg <= next_sysResetReg;
      wakeReg <= next_wakeReg;
    end
  end

  assign bvalid = bValidReg;
  assign bresp = bRespReg;
  assign rvalid = rValidReg;
  assign rdata = rDataReg;
  assign rresp = rRespReg;
  assign system_reset = sysResetReg;
  assign wake_nmi = wakeReg;
  assign irq = |(irqStatus & irqMask); // level while an unmasked event stands
endmodule : watchdog_control_regs
`default_nettype wire

/* test/watchdog_control_regs_monitor.sv */
// port assertions for the watchdog register block
`timescale 1ns/10ps
`default_nettype none
module watchdog_control_regs_monitor
  import watchdog_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] power_mode,
  input wire logic system_reset,
  input wire logic wake_nmi,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // register bus handshake
  // ---------------------------------------------------------------
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  // ---------------------------------------------------------------
  // timeout outcome
  // ---------------------------------------------------------------
  a_reset_pulse: assert property (system_reset |=> !system_reset)
    else $error("reset pulse too long");
  a_nmi_pulse: assert property (wake_nmi |=> !wake_nmi)
    else $error("wake pulse too long");
  a_one_outcome: assert property (!(system_reset && wake_nmi))
    else $error("reset and wake together");
  a_reset_awake: assert property (system_reset |-> $past(power_mode) == PM_AWAKE)
    else $error("reset while asleep");
  c_reset: cover property (system_reset);
  c_nmi: cover property (wake_nmi);
  c_irq: cover property (irq);
endmodule : watchdog_control_regs_monitor
bind watchdog_control_regs watchdog_control_regs_monitor watchdog_control_regs_monitor_i (
  .clk(clk),
  .resetn(resetn),
  .awvalid(awvalid),
  .awready(awready),
  .wvalid(wvalid),
  .wready(wready),
  .bresp(bresp),
  .bvalid(bvalid),
  .bready(bready),
  .arvalid(arvalid),
  .arready(arready),
  .rdata(rdata),
  .rresp(rresp),
  .rvalid(rvalid),
  .rready(rready),
  .power_mode(power_mode),
  .system_reset(system_reset),
  .wake_nmi(wake_nmi),
  .irq(irq)
);
`default_nettype wire

/* test/watchdog_control_regs_test.sv */
// self-checking bench for the watchdog register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; $display("FAIL %0t got %h exp %h", $time, a, e); end end
module watchdog_control_regs_test
  import watchdog_pkg::*;
;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, low_power_rc_osc;
  logic awready, wready, bvalid, arready, rvalid, system_reset, wake_nmi, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, config_word_one, got;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, power_mode, rsp;
  int error_cnt, compares, rstCnt, nmiCnt;
  watchdog_control_regs watchdog_control_regs_i (
    .clk(clk),
    .resetn(resetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .config_word_one(config_word_one),
    .low_power_rc_osc(low_power_rc_osc),
    .power_mode(power_mode),
    .system_reset(system_reset),
    .wake_nmi(wake_nmi),
    .irq(irq)
  );
  // clock
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // count outcome pulses
  always @(posedge clk)
  begin
    if (resetn === 1'b1 && system_reset !== 1'b0) rstCnt++; // an unknown counts too
    if (resetn === 1'b1 && wake_nmi !== 1'b0) nmiCnt++;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task close_out;
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task guard(input int n);
    if (n >= 50)
    begin
      error_cnt++;
      close_out;
    end
  endtask : guard
  task wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((aw || w) && n < 50)
    begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) aw = 0;
      if (wready === 1'b1) w = 0;
      if (!aw) awvalid <= 1'b0;
      if (!w) wvalid <= 1'b0;
    end
    // late ready lets the response wait on the bus
    repeat (2) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1 && ++n < 50);
    rsp = bresp;
    bready <= 1'b0;
    guard(n);
  endtask : wr
  task rd(input logic [31:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1 && ++n < 50);
    arvalid <= 1'b0;
    repeat (2) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1 && ++n < 50);
    got = rdata;
    rsp = rresp;
    rready <= 1'b0;
    guard(n);
  endtask : rd
  // oscillator ticks, then time for the pulse to land
  task tick(input int k);
    repeat (k)
    begin
      low_power_rc_osc <= 1'b1;
      repeat (4) @(posedge clk);
      low_power_rc_osc <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : tick
  task do_reset;
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, low_power_rc_osc} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    power_mode = PM_AWAKE;
    config_word_one = 32'h00020000;
    do_reset;
    rd(ADDR_CONTROL);
    `CHK(got, 32'h00000008)
    wr(ADDR_CONTROL, 32'h0000007C);
    `CHK(rsp, RESP_OKAY)
    rd(ADDR_CONTROL);
    `CHK(got, 32'h00000008)
    wr(ADDR_CONTROL_SET, 32'h00008000);
    rd(ADDR_CONTROL);
    `CHK(got, 32'h00008008)
    wr(ADDR_CONTROL_INV, 32'h00008000);
    rd(ADDR_CONTROL);
    `CHK(got, 32'h00000008)
    wr(ADDR_CONTROL, 32'h00008000);
    rd(ADDR_CONTROL_SET);
    `CHK(got, 32'h00000000)
    // low byte strobe only: the enable byte stays as it was
    wstrb <= 4'h1;
    wr(ADDR_CONTROL, 32'h00000000);
    wstrb <= 4'hF;
    rd(ADDR_CONTROL);
    `CHK(got, 32'h00008008)
    wr(ADDR_IRQ_MASK, 32'h00000010);
    tick(3);
    wr(ADDR_CONTROL_CLR, 32'h00008000);
    tick(2);
    wr(ADDR_CONTROL_SET, 32'h00008000);
    tick(3);
    `CHK(rstCnt, 0)
    wr(ADDR_CONTROL_SET, 32'h00000001);
    tick(3);
    `CHK(rstCnt, 0)
    tick(1);
    `CHK(rstCnt, 1)
    `CHK(irq, 1'b1)
    rd(ADDR_CAUSE);
    `CHK(got, 32'h00000010)
    wr(ADDR_IRQ_STATUS, 32'h00000010);
    `CHK(irq, 1'b0)
    wr(ADDR_CAUSE_CLR, 32'h00000010);
    wr(ADDR_IRQ_MASK, 32'h00000000);
    // sleep then idle: wake pulse and mode bit instead of reset
    for (int i = 0; i < 2; i++)
    begin
      power_mode <= i ? PM_IDLE : PM_SLEEP;
      tick(4);
      `CHK(nmiCnt, i + 1)
      rd(ADDR_CAUSE);
      `CHK(got, i ? 32'h00000014 : 32'h00000018)
      wr(ADDR_CAUSE_CLR, got);
    end
    `CHK(rstCnt, 1)
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 32'h00000010);
    `CHK(irq, 1'b1)
    rd(ADDR_CAUSE);
    `CHK(got, 32'h00000000)
    wr(ADDR_CAUSE_SET, 32'h00000010);
    wr(ADDR_CAUSE_INV, 32'h00000014);
    rd(ADDR_CAUSE);
    `CHK(got, 32'h00000004)
    rd(32'hBF800020);
    `CHK(rsp, RESP_SLVERR)
    wr(32'hBF800020, 32'h00000000);
    `CHK(rsp, RESP_SLVERR)
    // forced on by the fuse word, ratio 1:1
    power_mode <= PM_AWAKE;
    config_word_one <= 32'h00800000;
    do_reset;
    wr(ADDR_CONTROL_CLR, 32'h00008000);
    rd(ADDR_CONTROL);
    `CHK(got, 32'h00008000)
    tick(1);
    `CHK(rstCnt, 2)
    close_out;
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out;
  end
endmodule : watchdog_control_regs_test
`default_nettype wire
